/* rtl/asr_host.sv */
// How it works
// R1: the host reaches 262,144 words of 16 bits through the word address.
// R2: chip_select_n is held high between accesses so the memory sits in standby.
// R3: a write drives write_strobe_n and chip_select_n low together.
// R4: the memory captures data at the rising strobe, so data is held valid across it.
// R5: data pins are driven only once write_strobe_n is low and outputs are off.
// R6: a read holds write_strobe_n high with output_drive_n and chip_select_n low.
// R7: read data is sampled after the access time with the address held stable.
// R8: output_drive_n stays high in writes and idle so the memory never drives then.
// R9: the two byte lane selects follow the requested byte enables.
// R10: the address changes only while chip_select_n and write_strobe_n are high.
// R11: a write ends by raising write_strobe_n and chip_select_n together.
// R12: address is presented in the cycle before chip_select_n falls.
// R13: a request with no byte enabled completes without touching the memory.
// R14: the word address is an 18-bit binary index.
`timescale 1ns/100ps
`default_nettype none
module asr_host #(
    parameter int ADDR_WIDTH = asr_pkg::ADDR_WIDTH,
    parameter int DATA_WIDTH = asr_pkg::DATA_WIDTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_WIDTH-1:0] req_addr_in,
    input wire logic [DATA_WIDTH-1:0] req_wdata_in,
    input wire logic [asr_pkg::LANE_COUNT-1:0] req_lanes_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_WIDTH-1:0] rsp_rdata_out,
    output logic [ADDR_WIDTH-1:0] word_address_out,
    output logic chip_select_n_out,
    output logic write_strobe_n_out,
    output logic output_drive_n_out,
    output logic low_byte_lane_n_out,
    output logic high_byte_lane_n_out,
    input wire logic [DATA_WIDTH-1:0] data_pins_in,
    output logic [DATA_WIDTH-1:0] data_pins_out,
    output logic data_pins_oe_out
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // pins and counters are sized for one memory shape only
    if (ADDR_WIDTH != asr_pkg::ADDR_WIDTH || DATA_WIDTH != asr_pkg::DATA_WIDTH)
    begin : g_bad_width
        $error("asr_host: widths must match the memory");
    end
    if (DATA_WIDTH != asr_pkg::LANE_COUNT * asr_pkg::LANE_WIDTH)
    begin : g_bad_lanes
        $error("asr_host: byte lanes must cover the data width");
    end
    if ($clog2(asr_pkg::WORD_COUNT) != ADDR_WIDTH)
    begin : g_bad_depth
        $error("asr_host: address width must cover every word");
    end
    // a count that does not fit would wrap and cut the strobe short
    if ($clog2(asr_pkg::READ_CYCLES + 1) > asr_pkg::COUNT_WIDTH
        || $clog2(asr_pkg::WRITE_CYCLES + 1) > asr_pkg::COUNT_WIDTH
        || $clog2(asr_pkg::GAP_CYCLES + 1) > asr_pkg::COUNT_WIDTH)
    begin : g_bad_count
        $error("asr_host: counter too narrow for the access timing");
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    asr_pkg::asr_state_type state, next_state;
    logic [asr_pkg::COUNT_WIDTH-1:0] count, next_count;
    logic is_write, next_is_write;
    logic [ADDR_WIDTH-1:0] next_word_address;
    logic next_chip_select_n, next_write_strobe_n, next_output_drive_n;
    logic next_low_byte_lane_n, next_high_byte_lane_n;
    logic [DATA_WIDTH-1:0] next_data_pins, next_rsp_rdata;
    logic next_data_pins_oe, next_req_ready, next_rsp_valid;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_is_write = is_write;
        next_word_address = word_address_out;
        next_chip_select_n = chip_select_n_out;
        next_write_strobe_n = write_strobe_n_out;
        next_output_drive_n = output_drive_n_out;
        next_low_byte_lane_n = low_byte_lane_n_out;
        next_high_byte_lane_n = high_byte_lane_n_out;
        next_data_pins = data_pins_out;
        next_data_pins_oe = data_pins_oe_out;
        next_req_ready = req_ready_out;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata_out;
        case (state)
            asr_pkg::ASR_IDLE:
            begin
                if (req_valid_in && req_ready_out)
                begin
                    next_req_ready = 1'b0;
                    if (req_lanes_in == '0)
                    begin
                        // nothing enabled, answer at once and stay in standby
                        next_rsp_valid = 1'b1; // see R13
                        next_req_ready = 1'b1;
                    end
                    else
                    begin
                        next_word_address = req_addr_in; // see R10, R12, R14
                        next_low_byte_lane_n = ~req_lanes_in[0]; // see R9
                        next_high_byte_lane_n = ~req_lanes_in[1]; // see R9
                        next_is_write = req_write_in;
                        next_data_pins = req_wdata_in;
                        next_state = asr_pkg::ASR_SETUP;
                    end
                end
            end
            asr_pkg::ASR_SETUP:
            begin
                next_chip_select_n = 1'b0; // see R12
                if (is_write)
                begin
                    next_write_strobe_n = 1'b0; // see R3, R8
                    next_count = asr_pkg::COUNT_WIDTH'(asr_pkg::WRITE_CYCLES);
                    next_state = asr_pkg::ASR_WRITE;
                end
                else
                begin
                    next_output_drive_n = 1'b0; // see R6
                    next_count = asr_pkg::COUNT_WIDTH'(asr_pkg::READ_CYCLES);
                    next_state = asr_pkg::ASR_READ;
                end
            end
            asr_pkg::ASR_WRITE:
            begin
                // strobe is already low, memory drivers are off
                next_data_pins_oe = 1'b1; // see R5
                next_count = count - 1'b1;
                if (count == '0)
                begin
                    // data has stood a full pulse, release both strobes at once
                    next_write_strobe_n = 1'b1; // see R4, R11
                    next_chip_select_n = 1'b1; // see R11
                    next_count = asr_pkg::COUNT_WIDTH'(asr_pkg::GAP_CYCLES);
                    next_state = asr_pkg::ASR_GAP;
                end
            end
            asr_pkg::ASR_READ:
            begin
                next_count = count - 1'b1;
                if (count == '0)
                begin
                    next_rsp_rdata = data_pins_in; // see R7
                    next_rsp_valid = 1'b1;
                    next_output_drive_n = 1'b1; // see R8
                    next_chip_select_n = 1'b1; // see R2
                    next_count = asr_pkg::COUNT_WIDTH'(asr_pkg::GAP_CYCLES);
                    next_state = asr_pkg::ASR_GAP;
                end
            end
            asr_pkg::ASR_GAP:
            begin
                // keep data held past the strobe edge, then let the bus float
                next_data_pins_oe = 1'b0;
                next_count = count - 1'b1;
                if (count == '0)
                begin
                    if (is_write)
                    begin
                        next_rsp_valid = 1'b1;
                    end
                    next_low_byte_lane_n = 1'b1;
                    next_high_byte_lane_n = 1'b1;
                    next_req_ready = 1'b1;
                    next_state = asr_pkg::ASR_IDLE;
                end
            end
            default:
            begin
                next_state = asr_pkg::ASR_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers, every pin straight from a flip-flop
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= asr_pkg::ASR_IDLE;
            count <= '0;
            is_write <= 1'b0;
            word_address_out <= '0;
            chip_select_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            output_drive_n_out <= 1'b1;
            low_byte_lane_n_out <= 1'b1;
            high_byte_lane_n_out <= 1'b1;
            data_pins_out <= '0;
            data_pins_oe_out <= 1'b0;
            req_ready_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            is_write <= next_is_write;
            word_address_out <= next_word_address;
            chip_select_n_out <= next_chip_select_n;
            write_strobe_n_out <= next_write_strobe_n;
            output_drive_n_out <= next_output_drive_n;
            low_byte_lane_n_out <= next_low_byte_lane_n;
            high_byte_lane_n_out <= next_high_byte_lane_n;
            data_pins_out <= next_data_pins;
            data_pins_oe_out <= next_data_pins_oe;
            req_ready_out <= next_req_ready;
            rsp_valid_out <= next_rsp_valid;
            rsp_rdata_out <= next_rsp_rdata;
        end
    end
endmodule
`default_nettype wire

/* rtl/asr_pkg.sv */
package asr_pkg;
    localparam int ADDR_WIDTH = 18;
    localparam int DATA_WIDTH = 16;
    localparam int LANE_WIDTH = 8;
    localparam int LANE_COUNT = 2;
    localparam int WORD_COUNT = 262144;
    localparam int CLOCK_PERIOD_NS = 10;
    // access and write pulse figures of the slowest grade
    localparam int READ_ACCESS_NS = 20;
    localparam int WRITE_PULSE_NS = 20;
    localparam int DATA_SETUP_NS = 9;
    localparam int TURNAROUND_NS = 9;
    localparam int READ_CYCLES = (READ_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SETUP_CYCLES = (DATA_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int GAP_CYCLES = (TURNAROUND_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int COUNT_WIDTH = 4;

    typedef enum logic [4:0] {
        ASR_IDLE  = 5'b0_0001,
        ASR_SETUP = 5'b0_0010,
        ASR_READ  = 5'b0_0100,
        ASR_WRITE = 5'b0_1000,
        ASR_GAP   = 5'b1_0000
    } asr_state_type;
endpackage

/* tb/asr_host_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module asr_host_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_lanes_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [17:0] word_address_out,
    input wire logic chip_select_n_out,
    input wire logic write_strobe_n_out,
    input wire logic output_drive_n_out,
    input wire logic low_byte_lane_n_out,
    input wire logic high_byte_lane_n_out,
    input wire logic data_pins_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_drive; data_pins_oe_out |-> output_drive_n_out || !write_strobe_n_out; endproperty
    property p_hold; !chip_select_n_out |-> $stable(word_address_out); endproperty
    property p_wr; !write_strobe_n_out |-> !chip_select_n_out; endproperty
    property p_rd; !output_drive_n_out |-> write_strobe_n_out && !chip_select_n_out; endproperty
    property p_wlen;
        $fell(write_strobe_n_out) |-> !write_strobe_n_out[*3] ##1 (write_strobe_n_out && chip_select_n_out);
    endproperty
    property p_wdata; $rose(write_strobe_n_out) |-> data_pins_oe_out && $past(data_pins_oe_out); endproperty
    property p_rlen;
        $fell(output_drive_n_out) |-> !output_drive_n_out[*3] ##1 (output_drive_n_out && rsp_valid_out);
    endproperty
    property p_empty; req_valid_in && req_ready_out && req_lanes_in == 2'h0 |=> rsp_valid_out; endproperty
    property p_lane;
        req_valid_in && req_ready_out && req_lanes_in != 2'h0
            |=> {high_byte_lane_n_out, low_byte_lane_n_out} == ~$past(req_lanes_in);
    endproperty
    a_drive: assert property (p_drive) else $error("host drives data while memory may drive");
    a_hold: assert property (p_hold) else $error("address moved while selected");
    a_wr: assert property (p_wr) else $error("strobe low without select");
    a_rd: assert property (p_rd) else $error("output drive low outside a read");
    a_wlen: assert property (p_wlen) else $error("write pulse length wrong");
    a_wdata: assert property (p_wdata) else $error("data not held at strobe rise");
    a_rlen: assert property (p_rlen) else $error("read window wrong");
    a_empty: assert property (p_empty) else $error("empty request not answered");
    a_lane: assert property (p_lane) else $error("lane selects wrong");
    c_wr: cover property ($rose(write_strobe_n_out));
    c_rd: cover property ($rose(output_drive_n_out));
    c_empty: cover property (req_valid_in && req_ready_out && req_lanes_in == 2'h0);
    c_part: cover property (!write_strobe_n_out && low_byte_lane_n_out != high_byte_lane_n_out);
endmodule
bind asr_host asr_host_chk u_chk (.*);
`default_nettype wire

/* tb/asr_sram_model.sv */
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model (
    input wire logic [17:0] addr_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic lo_n_in,
    input wire logic hi_n_in,
    input wire logic host_oe_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out
);
    logic [15:0] mem [asr_pkg::WORD_COUNT];
    logic wr;
    logic rd;
    logic [15:0] bus;
    assign wr = !cs_n_in && !we_n_in;
    assign rd = !cs_n_in && we_n_in && !oe_n_in;
    // an undriven bus floats to the inverse of the host's last value
    assign bus = host_oe_in ? data_in : ~data_in;
    // one event even when both strobes rise together
    always @(negedge wr)
    begin
        if (!lo_n_in) mem[addr_in][7:0] = bus[7:0];
        if (!hi_n_in) mem[addr_in][15:8] = bus[15:8];
    end
    assign data_out[7:0] = rd && !lo_n_in ? mem[addr_in][7:0] : bus[7:0];
    assign data_out[15:8] = rd && !hi_n_in ? mem[addr_in][15:8] : bus[15:8];
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0, req_ready_out, rsp_valid_out;
    logic chip_select_n_out, write_strobe_n_out, output_drive_n_out, low_byte_lane_n_out;
    logic high_byte_lane_n_out, data_pins_oe_out;
    logic [17:0] req_addr_in = 0, word_address_out, a;
    logic [15:0] req_wdata_in = 0, rsp_rdata_out, data_pins_in, data_pins_out, q, d, e, e0;
    logic [1:0] req_lanes_in = 0, l;
    int error_cnt = 0, cmp_count = 0;
    always #5 clock_in = ~clock_in;
    asr_host u_asr_host (.*);
    asr_sram_model u_asr_sram_model (.addr_in(word_address_out), .cs_n_in(chip_select_n_out),
        .we_n_in(write_strobe_n_out), .oe_n_in(output_drive_n_out), .lo_n_in(low_byte_lane_n_out),
        .hi_n_in(high_byte_lane_n_out), .host_oe_in(data_pins_oe_out), .data_in(data_pins_out),
        .data_out(data_pins_in));
    function automatic logic [15:0] mask(input logic [1:0] m);
        return {{8{m[1]}}, {8{m[0]}}};
    endfunction
    function automatic logic [15:0] merge(input logic [15:0] old, upd, input logic [1:0] m);
        return (old & ~mask(m)) | (upd & mask(m));
    endfunction
    function automatic logic [15:0] idle_word();
        return {8'h00, req_ready_out, chip_select_n_out, write_strobe_n_out, output_drive_n_out,
            low_byte_lane_n_out, high_byte_lane_n_out, data_pins_oe_out, rsp_valid_out};
    endfunction
    task tally_and_finish;
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_hi(input bit rsp);
        for (int n = 0; (rsp ? rsp_valid_out : req_ready_out) !== 1'h1; n++)
        begin
            if (n > 20)
            begin
                $display("CHECK FAILED %s expected 1 seen %b", rsp ? "rsp_valid_out" : "req_ready_out",
                    rsp ? rsp_valid_out : req_ready_out);
                error_cnt++;
                tally_and_finish();
            end
            @(posedge clock_in) #1;
        end
    endtask
    task automatic xfer(input logic w, input logic [15:0] wd, input logic [1:0] ln);
        wait_hi(0);
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in, req_lanes_in} = {1'h1, w, a, wd, ln};
        @(posedge clock_in) #1 req_valid_in = 0;
        wait_hi(1);
        q = rsp_rdata_out;
        @(posedge clock_in) #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] x, got);
        cmp_count++;
        if (got !== x)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
        end
    endtask
    initial
    begin
        void'($urandom(32'h1045_0837));
        repeat (5) @(posedge clock_in);
        #1 rst_in = 0;
        chk("idle outputs", 16'h00fc, idle_word());
        for (int i = 0; i < 24; i++)
        begin
            a = i == 0 ? 18'h0_0000 : i == 1 ? 18'h3_ffff : 18'($urandom);
            e = 16'($urandom);
            xfer(1, e, 2'h3);
            if (i == 0) e0 = e;
            d = 16'($urandom);
            l = 2'(i);
            xfer(1, d, l);
            e = merge(e, d, l);
            l = 2'($urandom);
            xfer(0, 16'h0000, l);
            chk("rsp_rdata_out", e & mask(l), q & mask(l));
        end
        // reset in mid-run: pins go idle, stored words survive
        rst_in = 1;
        repeat (2) @(posedge clock_in);
        #1 rst_in = 0;
        chk("idle outputs", 16'h00fc, idle_word());
        a = 18'h0_0000;
        xfer(0, 16'h0000, 2'h3);
        chk("rsp_rdata_out", e0, q);
        tally_and_finish();
    end
endmodule
`default_nettype wire
